// >>> core/tcs_map.vh
// Purpose: Constants for the timecode select, monitor and mute block.
// Assumes: Clock of 10 MHz; timecode words are 32-bit running counts.
// Notes:   Included by bare name; definitions only.
`ifndef TCS_MAP_VH
`define TCS_MAP_VH

// ****************************************
// Timing
// ****************************************
`define TCS_CLK_KHZ     10000
`define TCS_FRAME_US    40000
`define TCS_FRAME_CYC   ((`TCS_FRAME_US * `TCS_CLK_KHZ) / 1000)

// ****************************************
// Linear timecode input source codes
// ****************************************
`define TCS_SRC_COM1    5'h00
`define TCS_SRC_COM2    5'h01
`define TCS_SRC_AUD1    5'h02
`define TCS_SRC_AUD16   5'h11

// ****************************************
// Priority slot codes and field layout
// ****************************************
`define TCS_PRI_W       3
`define TCS_PRI_LTC     3'h4
`define TCS_NSRC        5
`define TCS_NFMT        4

// ****************************************
// Reset values
// ****************************************
`define TCS_TC_RST      32'h0000_0000
`define TCS_LINE_RST    11'h000

`endif

// >>> core/tcs_top.v
// Purpose: Monitors four timecode formats and one linear timecode input,
//          picks a source by four priority slots, drives serial and audio
//          timecode outputs and strips incoming timecode packets.
// Assumes: All inputs come from logic on i_clk, so none are synchronised.
// Notes:   Timecode words are treated as opaque 32-bit running counts.
//          FRAME_CYC must fit in CNT_W bits.
`timescale 1ns/1ns
`default_nettype none
`include "tcs_map.vh"

module tcs_top #(
  parameter FRAME_CYC = `TCS_FRAME_CYC,
  parameter CNT_W     = 20
) (
  // Clock and reset
  input  wire         i_clk,
  input  wire         i_resetn,
  // Monitored formats, four 32-bit words and four 11-bit lines
  input  wire [3:0]   i_fmt_valid,
  input  wire [127:0] i_fmt_tc,
  input  wire [43:0]  i_fmt_line,
  // Serial port timecode words
  input  wire         i_com1_valid,
  input  wire [31:0]  i_com1_tc,
  input  wire         i_com1_is_ltc,
  input  wire         i_com2_valid,
  input  wire [31:0]  i_com2_tc,
  input  wire         i_com2_is_ltc,
  // Audio timecode words tagged by channel, 0 for channel 1
  input  wire         i_aud_valid,
  input  wire [3:0]   i_aud_ch,
  input  wire [31:0]  i_aud_tc,
  // Configuration
  input  wire [4:0]   i_ltc_src,
  input  wire [11:0]  i_prio,
  input  wire         i_mute_en,
  input  wire         i_pkt_rm_en,
  input  wire [1:0]   i_ins_fmt,
  input  wire         i_frame_tick,
  // Input video
  input  wire         i_vid_valid,
  input  wire [9:0]   i_vid_data,
  input  wire         i_vid_atc,
  // Format status
  output wire [3:0]   o_fmt_present,
  output wire [127:0] o_fmt_tc,
  output wire [43:0]  o_fmt_line,
  output wire         o_ltc_present,
  // Timecode outputs
  output wire [31:0]  o_rs485_tc,
  output wire [31:0]  o_aud_tc,
  output wire         o_aud_mute,
  output wire         o_tc_lost,
  output wire [2:0]   o_sel_src,
  output wire         o_ins_req,
  output wire [31:0]  o_ins_tc,
  output wire [1:0]   o_ins_fmt,
  // Output video
  output wire [3:0]   o_sdi_valid,
  output wire [39:0]  o_sdi_data
);

  // ****************************************
  // Priority pick
  // ****************************************
  // Slot 0 is scanned last, so it overrides every lower slot.
  function [3:0] tcs_pick;
    input [11:0] pri;
    input [4:0]  pres;
    integer      s;
    reg   [2:0]  c;
    begin
      tcs_pick = 4'h0;
      for (s = 3; s >= 0; s = s - 1) begin
        c = pri[3*s +: 3];
        if ((c <= `TCS_PRI_LTC) && pres[c]) begin
          tcs_pick = {1'b1, c};
        end
      end
    end
  endfunction

  // ****************************************
  // Storage
  // ****************************************
  reg [31:0]      tc_q   [0:3];
  reg [10:0]      line_q [0:3];
  reg [CNT_W-1:0] cnt_q  [0:3];
  reg [3:0]       fmt_pres_q;
  reg             ltc_pres_q;
  reg [31:0]      ltc_tc_q;
  reg [CNT_W-1:0] ltc_cnt_q;
  reg [31:0]      rs_q;
  reg [31:0]      aud_q;
  reg             mute_q;
  reg             lost_q;
  reg [2:0]       sel_q;
  reg             ins_q;
  reg [31:0]      ins_tc_q;
  reg [1:0]       ins_fmt_q;
  reg [3:0]       vld_q;
  reg [9:0]       dat_q;

  wire [4:0]  pres;
  wire [3:0]  pick;
  reg         ltc_acc;
  reg  [31:0] ltc_word;
  reg  [31:0] sel_tc;
  reg  [4:0]  aud_code;
  integer     k;

  // ****************************************
  // Frame timeout and free-run step
  // ****************************************
  // The limit is cut to CNT_W bits, so CNT_W must be wide enough to hold it.
  function tcs_expired;
    input [CNT_W-1:0] cnt;
    begin
      tcs_expired = (cnt == FRAME_CYC[CNT_W-1:0] - 1'b1);
    end
  endfunction

  function [CNT_W-1:0] tcs_count;
    input [CNT_W-1:0] cnt;
    begin
      tcs_count = cnt + 1'b1;
    end
  endfunction

  function [31:0] tcs_inc;
    input [31:0] tc;
    begin
      tcs_inc = tc + 32'h0000_0001;
    end
  endfunction

  // ****************************************
  // Linear timecode input selector
  // ****************************************
  // Codes above the last audio channel take no word at all.
  always @* begin
    ltc_acc  = 1'b0;
    ltc_word = i_aud_tc;
    aud_code = {1'b0, i_aud_ch} + `TCS_SRC_AUD1;
    if (i_ltc_src == `TCS_SRC_COM1) begin
      ltc_acc  = i_com1_valid & i_com1_is_ltc;
      ltc_word = i_com1_tc;
    end else if (i_ltc_src == `TCS_SRC_COM2) begin
      ltc_acc  = i_com2_valid & i_com2_is_ltc;
      ltc_word = i_com2_tc;
    end else if (i_ltc_src <= `TCS_SRC_AUD16) begin
      ltc_acc  = i_aud_valid & (aud_code == i_ltc_src);
    end
  end

  assign pres = {ltc_pres_q, fmt_pres_q};
  assign pick = tcs_pick(i_prio, pres);

  always @* begin
    if (pick[2:0] == `TCS_PRI_LTC) begin
      sel_tc = ltc_tc_q;
    end else begin
      sel_tc = tc_q[pick[1:0]];
    end
  end

  // ****************************************
  // Presence tracking
  // ****************************************
  // A new word wins over a timeout landing in the same cycle.
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      fmt_pres_q <= 4'h0;
      for (k = 0; k < `TCS_NFMT; k = k + 1) begin
        tc_q[k]   <= `TCS_TC_RST;
        line_q[k] <= `TCS_LINE_RST;
        cnt_q[k]  <= {CNT_W{1'b0}};
      end
    end else begin
      for (k = 0; k < `TCS_NFMT; k = k + 1) begin
        if (i_fmt_valid[k]) begin
          fmt_pres_q[k] <= 1'b1;
          cnt_q[k]      <= {CNT_W{1'b0}};
          tc_q[k]       <= i_fmt_tc[32*k +: 32];
          line_q[k]     <= i_fmt_line[11*k +: 11];
        end else if (fmt_pres_q[k]) begin
          if (tcs_expired(cnt_q[k])) begin
            fmt_pres_q[k] <= 1'b0;
            tc_q[k]       <= `TCS_TC_RST;
            line_q[k]     <= `TCS_LINE_RST;
            cnt_q[k]      <= {CNT_W{1'b0}};
          end else begin
            cnt_q[k] <= tcs_count(cnt_q[k]);
          end
        end
      end
    end
  end

  // The linear input has no line number, so it keeps its own register set.
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ltc_pres_q <= 1'b0;
      ltc_tc_q   <= `TCS_TC_RST;
      ltc_cnt_q  <= {CNT_W{1'b0}};
    end else if (ltc_acc) begin
      ltc_pres_q <= 1'b1;
      ltc_tc_q   <= ltc_word;
      ltc_cnt_q  <= {CNT_W{1'b0}};
    end else if (ltc_pres_q) begin
      if (tcs_expired(ltc_cnt_q)) begin
        ltc_pres_q <= 1'b0;
        ltc_tc_q   <= `TCS_TC_RST;
        ltc_cnt_q  <= {CNT_W{1'b0}};
      end else begin
        ltc_cnt_q <= tcs_count(ltc_cnt_q);
      end
    end
  end

  // ****************************************
  // Output timecode, failover and mute
  // ****************************************
  // Timecode outputs move only on the frame tick so both stay frame aligned.
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rs_q      <= `TCS_TC_RST;
      aud_q     <= `TCS_TC_RST;
      mute_q    <= 1'b0;
      lost_q    <= 1'b1;
      sel_q     <= 3'h0;
      ins_q     <= 1'b0;
      ins_tc_q  <= `TCS_TC_RST;
      ins_fmt_q <= 2'h0;
    end else begin
      ins_q <= 1'b0;
      if (i_frame_tick) begin
        lost_q <= ~pick[3];
        sel_q  <= pick[2:0];
        if (pick[3]) begin
          rs_q      <= sel_tc;
          aud_q     <= sel_tc;
          mute_q    <= 1'b0;
          ins_q     <= 1'b1;
          ins_tc_q  <= sel_tc;
          ins_fmt_q <= i_ins_fmt;
        end else if (i_mute_en) begin
          // A muted output requests no packet, so nothing stale is sent.
          mute_q <= 1'b1;
        end else begin
          rs_q      <= tcs_inc(rs_q);
          aud_q     <= tcs_inc(aud_q);
          mute_q    <= 1'b0;
          ins_q     <= 1'b1;
          ins_tc_q  <= tcs_inc(rs_q);
          ins_fmt_q <= i_ins_fmt;
        end
      end
    end
  end

  // ****************************************
  // Video path
  // ****************************************
  // One pipeline stage; removal drops words rather than blanking them.
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      vld_q <= 4'h0;
      dat_q <= 10'h000;
    end else begin
      vld_q <= {4{i_vid_valid & ~(i_pkt_rm_en & i_vid_atc)}};
      dat_q <= i_vid_data;
    end
  end

  assign o_fmt_present = fmt_pres_q;
  assign o_fmt_tc      = {tc_q[3], tc_q[2], tc_q[1], tc_q[0]};
  assign o_fmt_line    = {line_q[3], line_q[2], line_q[1], line_q[0]};
  assign o_ltc_present = ltc_pres_q;
  assign o_rs485_tc    = rs_q;
  assign o_aud_tc      = aud_q;
  assign o_aud_mute    = mute_q;
  assign o_tc_lost     = lost_q;
  assign o_sel_src     = sel_q;
  assign o_ins_req     = ins_q;
  assign o_ins_tc      = ins_tc_q;
  assign o_ins_fmt     = ins_fmt_q;
  assign o_sdi_valid   = vld_q;
  assign o_sdi_data    = {4{dat_q}};

endmodule
`default_nettype wire

// >>> tb/tcs_checker.sv
// Purpose: Port assertions for the timecode block.
// Assumes: One clock; reset asynchronous, active low.
// Notes:   Bound from the testbench top.
`timescale 1ns/1ns
`default_nettype none
module tcs_checker (
  // Watched ports
  input wire logic        i_clk,
  input wire logic        i_resetn,
  input wire logic        i_mute_en,
  input wire logic        i_pkt_rm_en,
  input wire logic        i_frame_tick,
  input wire logic        i_vid_valid,
  input wire logic        i_vid_atc,
  input wire logic [9:0]  i_vid_data,
  input wire logic [31:0] o_rs485_tc,
  input wire logic        o_aud_mute,
  input wire logic        o_tc_lost,
  input wire logic        o_ins_req,
  input wire logic [3:0]  o_sdi_valid,
  input wire logic [39:0] o_sdi_data
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  sequence s_answer; ##1 (o_ins_req ^ o_aud_mute); endsequence
  property p_sdi_valid; 1 |=> o_sdi_valid ==
    {4{$past(i_vid_valid && !(i_pkt_rm_en && i_vid_atc))}}; endproperty
  a_sdi_valid: assert property (p_sdi_valid) else $error("sdi valid");
  property p_sdi_data;
    1 |=> o_sdi_data == {4{$past(i_vid_data)}}; endproperty
  a_sdi_data: assert property (p_sdi_data) else $error("sdi data");
  property p_freeze; o_aud_mute |-> $stable(o_rs485_tc); endproperty
  a_freeze: assert property (p_freeze) else $error("not frozen");
  property p_mute_src;
    $rose(o_aud_mute) |-> $past(i_mute_en && i_frame_tick); endproperty
  a_mute_src: assert property (p_mute_src) else $error("mute cause");
  property p_free_run; o_tc_lost && !$stable(o_rs485_tc) |->
    o_rs485_tc == $past(o_rs485_tc) + 32'h0000_0001; endproperty
  a_free_run: assert property (p_free_run) else $error("free run");
  property p_no_mute;
    i_frame_tick && !i_mute_en |=> !o_aud_mute; endproperty
  a_no_mute: assert property (p_no_mute) else $error("muted");
  property p_tick; i_frame_tick |-> s_answer; endproperty
  a_tick: assert property (p_tick) else $error("tick answer");
  property p_ins;
    o_ins_req |-> $past(i_frame_tick) && !o_aud_mute; endproperty
  a_ins: assert property (p_ins) else $error("insert cause");
endmodule
`default_nettype wire

// >>> tb/tcs_vid_src.sv
// Purpose: Random input video source for the timecode block.
// Assumes: Words change just after each rising edge.
// Notes:   Data is random even when not valid, so stale words show.
`timescale 1ns/1ns
`default_nettype none
module tcs_vid_src (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_resetn,
  // Video words
  output var  logic       o_valid,
  output var  logic       o_atc,
  output var  logic [9:0] o_data
);
  integer seed = 32'h4f2e;
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      {o_valid, o_atc, o_data} <= 12'h000;
    end else begin
      {o_valid, o_atc, o_data} <= 12'($random(seed));
    end
  end
endmodule
`default_nettype wire

// >>> tb/timecode_source_select_mute_tb_top.sv
// Purpose: Self-checking bench for the timecode block.
// Assumes: Frame timeout shortened to 20 cycles.
// Notes:   Video is random from the source model; assertions judge it.
`timescale 1ns/1ns
`default_nettype none
module timecode_source_select_mute_tb_top;
  localparam integer FC = 20;
  logic         i_clk, i_resetn, i_com1_valid, i_com1_is_ltc, i_com2_valid;
  logic         i_com2_is_ltc, i_aud_valid, i_mute_en, i_pkt_rm_en;
  logic         i_frame_tick, i_vid_valid, i_vid_atc, o_ltc_present;
  logic         o_aud_mute, o_tc_lost, o_ins_req;
  logic [3:0]   i_fmt_valid, i_aud_ch, o_fmt_present, o_sdi_valid;
  logic [127:0] i_fmt_tc, o_fmt_tc;
  logic [43:0]  i_fmt_line, o_fmt_line;
  logic [31:0]  i_com1_tc, i_com2_tc, i_aud_tc, o_rs485_tc, o_aud_tc, o_ins_tc;
  logic [31:0]  w, v;
  logic [4:0]   i_ltc_src;
  logic [11:0]  i_prio;
  logic [1:0]   i_ins_fmt, o_ins_fmt;
  logic [9:0]   i_vid_data;
  logic [2:0]   o_sel_src;
  logic [39:0]  o_sdi_data;
  integer       seed = 32'h4f2e, mismatches = 0, comparisons = 0, k;
  tcs_top #(.FRAME_CYC(FC)) i_dut (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_fmt_valid(i_fmt_valid),
    .i_fmt_tc(i_fmt_tc), .i_fmt_line(i_fmt_line),
    .i_com1_valid(i_com1_valid), .i_com1_tc(i_com1_tc),
    .i_com1_is_ltc(i_com1_is_ltc), .i_com2_valid(i_com2_valid),
    .i_com2_tc(i_com2_tc), .i_com2_is_ltc(i_com2_is_ltc),
    .i_aud_valid(i_aud_valid), .i_aud_ch(i_aud_ch), .i_aud_tc(i_aud_tc),
    .i_ltc_src(i_ltc_src), .i_prio(i_prio), .i_mute_en(i_mute_en),
    .i_pkt_rm_en(i_pkt_rm_en), .i_ins_fmt(i_ins_fmt),
    .i_frame_tick(i_frame_tick), .i_vid_valid(i_vid_valid),
    .i_vid_data(i_vid_data), .i_vid_atc(i_vid_atc),
    .o_fmt_present(o_fmt_present), .o_fmt_tc(o_fmt_tc),
    .o_fmt_line(o_fmt_line), .o_ltc_present(o_ltc_present),
    .o_rs485_tc(o_rs485_tc), .o_aud_tc(o_aud_tc), .o_aud_mute(o_aud_mute),
    .o_tc_lost(o_tc_lost), .o_sel_src(o_sel_src), .o_ins_req(o_ins_req),
    .o_ins_tc(o_ins_tc), .o_ins_fmt(o_ins_fmt),
    .o_sdi_valid(o_sdi_valid), .o_sdi_data(o_sdi_data));
  tcs_vid_src i_src (.i_clk, .i_resetn, .o_valid(i_vid_valid),
    .o_atc(i_vid_atc), .o_data(i_vid_data));
  function automatic logic [31:0] frun(input logic [31:0] t);
    return t + 32'h0000_0001;
  endfunction
  task chk(input logic [127:0] seen, input logic [127:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: saw %h, want %h", $time, seen, exp);
    end
  endtask
  task results;
    $display("Compares %0d, mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task wt(input integer n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  // Pulses are dropped on the next edge, which is also the capture edge.
  task fin;
    @(posedge i_clk) begin
      {i_fmt_valid, i_com1_valid, i_com2_valid, i_aud_valid} <= 7'h00;
      i_frame_tick <= 1'b0;
    end
    #1;
  endtask
  task tick;
    @(posedge i_clk) i_frame_tick <= 1'b1;
    fin;
  endtask
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  initial begin
    #500000;
    mismatches++;
    results;
  end
  initial begin
    {i_fmt_valid, i_com1_valid, i_com2_valid, i_aud_valid, i_frame_tick} = 0;
    {i_com1_is_ltc, i_com2_is_ltc, i_mute_en, i_pkt_rm_en, i_aud_ch} = 0;
    {i_fmt_tc, i_fmt_line, i_com1_tc, i_com2_tc, i_aud_tc} = 0;
    {i_ltc_src, i_prio, i_ins_fmt, i_resetn} = {5'h00, 12'h917, 2'h1, 1'b0};
    wt(5);
    chk({o_tc_lost, o_fmt_present}, 5'h10);
    @(posedge i_clk) i_resetn <= 1'b1;
    for (k = 0; k < 4; k++) begin
      w = $random(seed);
      @(posedge i_clk) begin
        i_fmt_valid <= 4'h1 << k;
        i_fmt_tc[32*k +: 32] <= w;
        i_fmt_line[11*k +: 11] <= w[10:0];
      end
      fin;
      chk({o_fmt_present[k], o_fmt_tc[32*k +: 32]}, {1'b1, w});
      chk(o_fmt_line[11*k +: 11], w[10:0]);
      wt(FC - 3);
      chk(o_fmt_present[k], 1'b1);
      wt(4);
      chk({o_fmt_present[k], o_fmt_tc[32*k +: 32]}, 0);
    end
    $display("Test formats done");
    for (k = 0; k < 18; k++) begin
      @(posedge i_clk) begin
        {i_ltc_src, i_com1_is_ltc, i_com2_is_ltc} <= {k[4:0], 2'b00};
        {i_com1_valid, i_com2_valid, i_aud_valid} <= 3'h7;
        i_aud_ch <= k[3:0] - 4'h1;
      end
      fin;
      chk(o_ltc_present, 1'b0);
      @(posedge i_clk) begin
        {i_com1_is_ltc, i_com2_is_ltc, i_aud_ch} <= {2'b11, k[3:0] - 4'h2};
        {i_com1_valid, i_com2_valid, i_aud_valid} <= {k==0, k==1, k>1};
      end
      fin;
      chk(o_ltc_present, 1'b1);
      wt(FC + 4);
    end
    $display("Test linear sources done");
    w = $random(seed);
    v = 32'hffff_ffff;
    @(posedge i_clk) begin
      {i_fmt_valid, i_fmt_tc[95:64]} <= {4'h4, w};
      i_ins_fmt <= 2'h2;
    end
    fin;
    tick;
    chk({o_rs485_tc, o_aud_tc, o_ins_tc}, {w, w, w});
    chk({o_sel_src, o_aud_mute, o_tc_lost, o_ins_req, o_ins_fmt}, 8'h46);
    wt(FC + 4);
    @(posedge i_clk) begin
      {i_ltc_src, i_com1_valid} <= {5'h00, 1'b1};
      i_com1_tc <= v;
    end
    fin;
    tick;
    chk({o_rs485_tc, o_sel_src}, {v, 3'h4});
    wt(FC + 4);
    @(posedge i_clk) i_pkt_rm_en <= 1'b1;
    tick;
    chk({o_rs485_tc, o_aud_tc}, {frun(v), frun(v)});
    chk({o_aud_mute, o_tc_lost}, 2'b01);
    chk({o_ins_req, o_ins_tc}, {1'b1, frun(v)});
    @(posedge i_clk) i_mute_en <= 1'b1;
    tick;
    chk({o_rs485_tc, o_aud_mute, o_ins_req}, {frun(v), 2'b10});
    @(posedge i_clk) {i_fmt_valid, i_fmt_tc[95:64]} <= {4'h4, w};
    fin;
    tick;
    chk({o_rs485_tc, o_aud_mute, o_tc_lost}, {w, 2'b00});
    $display("Test priority and mute done");
    for (k = 0; k < 64; k++) begin
      @(posedge i_clk) i_pkt_rm_en <= k[2];
    end
    $display("Test video done");
    results;
  end
endmodule
bind tcs_top tcs_checker i_chk (.i_clk(i_clk), .i_resetn(i_resetn),
  .i_mute_en(i_mute_en), .i_pkt_rm_en(i_pkt_rm_en),
  .i_frame_tick(i_frame_tick), .i_vid_valid(i_vid_valid),
  .i_vid_atc(i_vid_atc), .i_vid_data(i_vid_data),
  .o_rs485_tc(o_rs485_tc), .o_aud_mute(o_aud_mute),
  .o_tc_lost(o_tc_lost), .o_ins_req(o_ins_req),
  .o_sdi_valid(o_sdi_valid), .o_sdi_data(o_sdi_data));
`default_nettype wire
